// [hdl/lcd_mux_drive_timing_cfg.svh]
// Offsets, field positions, reset values and timing counts of the LCD drive timing block
`ifndef LCD_MUX_DRIVE_TIMING_CFG_SVH
`define LCD_MUX_DRIVE_TIMING_CFG_SVH
`define SEG_COUNT 80
`define BP_COUNT 4
`define CLK_HZ 40000000
`define INIT_TIME_US 1000
`define INIT_CYCLES (`INIT_TIME_US * (`CLK_HZ / 1000000))
`define FRAME_DIV 24
`define FRAME_HZ 64
`define OSC_DIV_CYCLES (`CLK_HZ / (`FRAME_HZ * `FRAME_DIV))
`define REG_CTRL 8'h00
`define REG_POINTER 8'h04
`define REG_STATUS 8'h08
`define CTRL_RESET 7'h03
`define PTR_POS 0
`define SUBADDR_POS 8
`define ST_INIT_DONE_POS 0
`define ST_EXT_CLK_POS 1
`define ST_STRAP_DONE_POS 2
`define ST_SLOT_POS 4
`define ST_SYNC_POS 8
`define LVL_VSS 2'h0
`define LVL_LOW 2'h1
`define LVL_HIGH 2'h2
`define LVL_LCD_SUPPLY 2'h3
`endif

// [hdl/lcd_mux_drive_timing_pkg.sv]
// Types of the LCD drive timing block
`include "lcd_mux_drive_timing_cfg.svh"
package lcd_mux_drive_timing_pkg;
  typedef logic [1:0] level_t;
  typedef enum logic [1:0] {MUX_STATIC, MUX_1_2, MUX_1_3, MUX_1_4} mux_e;
  typedef struct packed {
    logic bank_out;
    logic bank_in;
    logic blink_en;
    logic disp_en;
    logic bias_half;
    mux_e mux;
  } ctrl_s;
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;
  typedef logic [`BP_COUNT-1:0][`SEG_COUNT-1:0] ram_cols_t;
  typedef logic [`SEG_COUNT-1:0][1:0] seg_levels_t;
  typedef logic [`BP_COUNT-1:0][1:0] bp_levels_t;
  typedef struct packed {
    ctrl_s ctrl;
    logic [6:0] ptr;
    logic [2:0] subaddr;
    logic [1:0] osc_sync;
    logic [1:0] clk_sync;
    logic [1:0] sync_sync;
    logic clk_prev;
    logic sync_prev;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic ext_sel;
    logic [15:0] div_cnt;
    logic clk_out;
    logic [3:0] tick_cnt;
    logic [2:0] slot;
    logic sync_drive;
    logic [15:0] init_cnt;
    logic init_done;
    logic any_wr;
    logic [31:0] prdata;
    bp_levels_t bp;
    seg_levels_t seg;
  } state_s;
endpackage

// [hdl/lcd_mux_drive_timing.sv]
// Clock selection, power-on state and frame timing of a multiplexed segment LCD driver
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "lcd_mux_drive_timing_cfg.svh"

module lcd_mux_drive_timing #(
  parameter int unsigned OSC_DIV = `OSC_DIV_CYCLES,
  parameter int unsigned INIT_CYCLES = `INIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire lcd_mux_drive_timing_pkg::apb_req_s apb_i,
  output lcd_mux_drive_timing_pkg::apb_rsp_s apb_o,
  input wire logic oscillator_source_select_i,
  input wire logic clk_pad_i,
  output logic clk_pad_o,
  output logic clk_pad_oe_o,
  input wire logic sync_n_i,
  output logic sync_n_o,
  output logic sync_n_oe_o,
  input wire lcd_mux_drive_timing_pkg::ram_cols_t display_latch_i,
  output lcd_mux_drive_timing_pkg::bp_levels_t backplane_out_o,
  output lcd_mux_drive_timing_pkg::seg_levels_t segment_outputs_o
);
  import lcd_mux_drive_timing_pkg::*;

  state_s st_q;
  state_s st_d;
  logic [2:0] n_bp;
  logic [3:0] slot_len;
  logic [2:0] last_slot;
  logic pol;
  logic [1:0] row;
  logic [1:0] bit_idx;
  logic tick;
  logic sync_fall;
  logic frame_start;
  logic setup;
  logic access;
  logic hit;
  logic [31:0] rd_word;
  logic third;
  logic realign;

  // ---------------------------------------------------------------
  // Frame sequencing helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] bp_row(input int k, input mux_e m);
    logic [1:0] r;
    r = 2'(k);
    case (m)
      MUX_STATIC: r = 2'h0;
      MUX_1_2: r = {1'b0, r[0]};
      MUX_1_3: r = (k == 3) ? 2'h1 : r;
      default: r = 2'(k);
    endcase
    return r;
  endfunction

  assign n_bp = {1'b0, st_q.ctrl.mux} + 3'h1;
  assign slot_len = 4'(`FRAME_DIV / (2 * int'(n_bp)));
  assign last_slot = 3'({n_bp, 1'b0} - 4'h1);
  assign pol = st_q.slot >= n_bp;
  // Static drive has a single row, whatever slot a mode change left behind
  assign row = (st_q.ctrl.mux == MUX_STATIC) ? 2'h0
               : (pol ? 2'(st_q.slot - n_bp) : 2'(st_q.slot));
  assign bit_idx = row | ((st_q.ctrl.bank_out && st_q.ctrl.mux <= MUX_1_2) ? 2'h2 : 2'h0);
  assign third = !st_q.ctrl.bias_half && st_q.ctrl.mux != MUX_STATIC;
  assign tick = st_q.strap_done && (st_q.ext_sel ? (st_q.clk_sync[1] && !st_q.clk_prev)
                                                 : (st_q.div_cnt == 16'(OSC_DIV - 1)));
  assign sync_fall = !st_q.sync_sync[1] && st_q.sync_prev;
  assign frame_start = tick && !sync_fall && st_q.slot == last_slot
                       && st_q.tick_cnt == slot_len - 4'h1;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  assign setup = apb_i.psel && !apb_i.penable;
  assign access = apb_i.psel && apb_i.penable;
  assign hit = apb_i.paddr == `REG_CTRL || apb_i.paddr == `REG_POINTER
               || apb_i.paddr == `REG_STATUS;

  always_comb
  begin
    rd_word = 32'h0;
    case (apb_i.paddr)
      `REG_CTRL: rd_word = {25'h0, st_q.ctrl};
      `REG_POINTER: rd_word = {21'h0, st_q.subaddr, 1'b0, st_q.ptr};
      `REG_STATUS:
      begin
        rd_word[`ST_INIT_DONE_POS] = st_q.init_done;
        rd_word[`ST_EXT_CLK_POS] = st_q.ext_sel;
        rd_word[`ST_STRAP_DONE_POS] = st_q.strap_done;
        rd_word[`ST_SLOT_POS +: 3] = st_q.slot;
        rd_word[`ST_SYNC_POS] = st_q.sync_drive;
      end
      default: rd_word = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.osc_sync = {st_q.osc_sync[0], oscillator_source_select_i};
    st_d.clk_sync = {st_q.clk_sync[0], clk_pad_i};
    st_d.sync_sync = {st_q.sync_sync[0], sync_n_i};
    st_d.clk_prev = st_q.clk_sync[1];
    st_d.sync_prev = st_q.sync_sync[1];
    // Strap captured once the synchroniser has filled
    if (!st_q.strap_done)
    begin
      st_d.strap_cnt = st_q.strap_cnt + 2'h1;
      if (st_q.strap_cnt == 2'h2)
      begin
        st_d.strap_done = 1'b1;
        st_d.ext_sel = st_q.osc_sync[1];
      end
    end
    // Internal oscillator divider and pad clock
    st_d.div_cnt = (st_q.div_cnt == 16'(OSC_DIV - 1)) ? 16'h0 : st_q.div_cnt + 16'h1;
    st_d.clk_out = st_q.div_cnt < 16'(OSC_DIV / 2);
    // Reset completion counter
    if (!st_q.init_done)
    begin
      st_d.init_cnt = st_q.init_cnt + 16'h1;
      st_d.init_done = st_q.init_cnt == 16'(INIT_CYCLES - 1);
    end
    // Frame slots, re-aligned by a partner's sync
    if (sync_fall)
    begin
      st_d.tick_cnt = 4'h0;
      st_d.slot = 3'h0;
    end
    else if (tick)
    begin
      if (st_q.tick_cnt >= slot_len - 4'h1 || st_q.slot > last_slot)
      begin
        st_d.tick_cnt = 4'h0;
        st_d.slot = (st_q.slot >= last_slot) ? 3'h0 : st_q.slot + 3'h1;
      end
      else
      begin
        st_d.tick_cnt = st_q.tick_cnt + 4'h1;
      end
    end
    st_d.sync_drive = st_q.ctrl.disp_en && st_d.slot == 3'h0;
    // Register reads and writes
    if (setup)
    begin
      st_d.prdata = rd_word;
    end
    if (access && apb_i.pwrite && hit)
    begin
      st_d.any_wr = 1'b1;
      if (apb_i.paddr == `REG_CTRL)
      begin
        st_d.ctrl = ctrl_s'(apb_i.pwdata[6:0]);
      end
      if (apb_i.paddr == `REG_POINTER)
      begin
        st_d.ptr = apb_i.pwdata[`PTR_POS +: 7];
        st_d.subaddr = apb_i.pwdata[`SUBADDR_POS +: 3];
      end
    end
    // Output levels
    for (int k = 0; k < `BP_COUNT; k++)
    begin
      if (!st_q.ctrl.disp_en)
      begin
        st_d.bp[k] = `LVL_LCD_SUPPLY;
      end
      else if (bp_row(k, st_q.ctrl.mux) == row)
      begin
        st_d.bp[k] = pol ? `LVL_VSS : `LVL_LCD_SUPPLY;
      end
      else
      begin
        st_d.bp[k] = third ? (pol ? `LVL_HIGH : `LVL_LOW) : `LVL_LOW;
      end
    end
    for (int k = 0; k < `SEG_COUNT; k++)
    begin
      if (!st_q.ctrl.disp_en)
      begin
        st_d.seg[k] = `LVL_LCD_SUPPLY;
      end
      else if (display_latch_i[bit_idx][k])
      begin
        st_d.seg[k] = pol ? `LVL_LCD_SUPPLY : `LVL_VSS;
      end
      else if (third)
      begin
        st_d.seg[k] = pol ? `LVL_LOW : `LVL_HIGH;
      end
      else
      begin
        st_d.seg[k] = pol ? `LVL_VSS : `LVL_LCD_SUPPLY;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= '0;
      st_q.ctrl <= ctrl_s'(`CTRL_RESET);
      st_q.osc_sync <= 2'h0;
      st_q.bp <= {`BP_COUNT{`LVL_LCD_SUPPLY}};
      st_q.seg <= {`SEG_COUNT{`LVL_LCD_SUPPLY}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign apb_o.prdata = st_q.prdata;
  assign apb_o.pready = 1'b1;
  assign apb_o.pslverr = access && !hit;
  assign clk_pad_o = st_q.clk_out;
  assign clk_pad_oe_o = st_q.strap_done && !st_q.ext_sel;
  assign sync_n_o = 1'b0;
  assign sync_n_oe_o = st_q.sync_drive;
  assign backplane_out_o = st_q.bp;
  assign segment_outputs_o = st_q.seg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [4:0] hlp_ticks_q;
  logic hlp_ok_q;
  // Own sync at frame start moves nothing
  assign realign = sync_fall && (tick || st_q.slot != 3'h0 || st_q.tick_cnt != 4'h0);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hlp_ticks_q <= 5'h0;
      hlp_ok_q <= 1'b0;
    end
    else
    begin
      hlp_ticks_q <= frame_start ? 5'h0 : (tick ? hlp_ticks_q + 5'h1 : hlp_ticks_q);
      hlp_ok_q <= frame_start ? 1'b1
                  : ((realign || (access && apb_i.paddr == `REG_CTRL)) ? 1'b0 : hlp_ok_q);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_disabled_supply;
    !st_q.ctrl.disp_en |=> backplane_out_o == {`BP_COUNT{`LVL_LCD_SUPPLY}}
                           && segment_outputs_o == {`SEG_COUNT{`LVL_LCD_SUPPLY}};
  endproperty
  a_disabled_supply: assert property (p_disabled_supply) else $error("outputs left supply");
  property p_por_mode;
    !st_q.any_wr |-> st_q.ctrl.mux == MUX_1_4 && !st_q.ctrl.bias_half && !st_q.ctrl.blink_en;
  endproperty
  a_por_mode: assert property (p_por_mode) else $error("bad power-on mode");
  property p_por_ptr;
    !st_q.any_wr |-> st_q.ptr == 7'h0 && st_q.subaddr == 3'h0 && !st_q.ctrl.bank_in
                     && !st_q.ctrl.bank_out && !st_q.ctrl.disp_en;
  endproperty
  a_por_ptr: assert property (p_por_ptr) else $error("bad power-on pointers");
  property p_clk_out;
    st_q.strap_done && !st_q.ext_sel && st_q.div_cnt == 16'h0 |=> clk_pad_oe_o && clk_pad_o;
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock pad not driven");
  property p_ext_in;
    st_q.ext_sel |-> !clk_pad_oe_o;
  endproperty
  a_ext_in: assert property (p_ext_in) else $error("clock pad driven in external mode");
  property p_frame_div;
    frame_start && hlp_ok_q |-> hlp_ticks_q == 5'd23;
  endproperty
  a_frame_div: assert property (p_frame_div) else $error("frame not 24 ticks");
  property p_strap_fixed;
    st_q.strap_done |=> st_q.strap_done && $stable(st_q.ext_sel) ##1 $stable(st_q.ext_sel);
  endproperty
  a_strap_fixed: assert property (p_strap_fixed) else $error("clock source changed");
  property p_sync_drive;
    st_q.ctrl.disp_en && st_q.slot == 3'h0 && !tick && !sync_fall |=> sync_n_oe_o;
  endproperty
  a_sync_drive: assert property (p_sync_drive) else $error("sync not driven");
  property p_static_levels;
    st_q.ctrl.disp_en && st_q.ctrl.mux == MUX_STATIC ##1 $stable(st_q.ctrl)
      |-> backplane_out_o[0] != `LVL_LOW && backplane_out_o[0] != `LVL_HIGH
          && backplane_out_o[3] == backplane_out_o[0];
  endproperty
  a_static_levels: assert property (p_static_levels) else $error("static level wrong");
  property p_mode_write;
    access && apb_i.pwrite && apb_i.paddr == `REG_CTRL
      |=> st_q.ctrl == ctrl_s'($past(apb_i.pwdata[6:0]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not taken");
  property p_half_bp;
    st_q.ctrl.bias_half ##1 st_q.ctrl.bias_half |-> backplane_out_o[1] != `LVL_HIGH;
  endproperty
  a_half_bp: assert property (p_half_bp) else $error("half bias used third level");

  c_frame: cover property (frame_start && hlp_ok_q);
  c_sync_in: cover property (sync_fall && st_q.ctrl.disp_en);
  c_half_1_4: cover property (st_q.ctrl.disp_en && st_q.ctrl.bias_half
                              && st_q.ctrl.mux == MUX_1_4 && tick);
  c_bank: cover property (st_q.ctrl.bank_out && st_q.ctrl.mux == MUX_1_2 && st_q.ctrl.disp_en);
endmodule

// [verification/lcd_panel_model.sv]
// LCD panel model watching the backplane drive for a frozen DC state
`timescale 1ns/10ps
module lcd_panel_model #(
  parameter int LIMIT = 400
) (
  input wire logic clk_i,
  input wire lcd_mux_drive_timing_pkg::bp_levels_t backplane_i,
  output logic dc_stuck_o
);
  import lcd_mux_drive_timing_pkg::*;
  bp_levels_t last_q;
  int same_q = 0;
  logic stuck_q = 1'b0;
  assign dc_stuck_o = stuck_q;
  // Flags a drive that stops changing while not parked at supply
  always @(posedge clk_i)
  begin
    last_q <= backplane_i;
    same_q <= (backplane_i == last_q && backplane_i != '1) ? same_q + 1 : 0;
    if (same_q > LIMIT)
      stuck_q <= 1'b1;
  end
endmodule

// [verification/tb.sv]
// Self-checking bench of the LCD drive timing block
`timescale 1ns/10ps
module tb;
  import lcd_mux_drive_timing_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic strap = 1'b0;
  logic pad_ext = 1'b0;
  logic sync_pull = 1'b0;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  logic pad_oe, pad_o, sync_o, sync_oe, dc_stuck, err;
  ram_cols_t latch = '0;
  bp_levels_t bp;
  seg_levels_t seg;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [6:0] modes [7] = '{7'h08, 7'h0d, 7'h09, 7'h0a, 7'h0e, 7'h0f, 7'h0b};
  // Pad and open-drain sync wire with pull-up
  wire pad_w = pad_oe ? pad_o : pad_ext;
  wire sync_w = !(sync_oe && !sync_o) && !sync_pull;

  lcd_mux_drive_timing #(.OSC_DIV(4), .INIT_CYCLES(20)) lcd_mux_drive_timing_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(req), .apb_o(rsp),
    .oscillator_source_select_i(strap), .clk_pad_i(pad_w), .clk_pad_o(pad_o),
    .clk_pad_oe_o(pad_oe), .sync_n_i(sync_w), .sync_n_o(sync_o), .sync_n_oe_o(sync_oe),
    .display_latch_i(latch), .backplane_out_o(bp), .segment_outputs_o(seg)
  );
  lcd_panel_model lcd_panel_model_inst (.clk_i(clk_i), .backplane_i(bp), .dc_stuck_o(dc_stuck));

  initial forever #12.5 clk_i = ~clk_i;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do @(posedge clk_i); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk_i);
  endtask

  task wait_rise;
    while (bp[0] === 2'h3) @(posedge clk_i);
    while (bp[0] !== 2'h3) @(posedge clk_i);
  endtask

  task summarize;
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Timeout and free-running external clock
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc % 5 == 0)
      pad_ext <= ~pad_ext;
    if (cyc == 30000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    time t;
    logic p;
    logic third;
    latch[0][0] <= 1'b1;
    latch[2][1] <= 1'b1;
    repeat (16) @(posedge clk_i);
    check(32'(bp), 32'hff);
    check({31'h0, &seg}, 32'h1);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    apb(8'h00, 1'b0, 32'h0);
    check(rd, 32'h03);
    apb(8'h04, 1'b0, 32'h0);
    check(rd, 32'h0);
    apb(8'h08, 1'b0, 32'h0);
    check(32'(rd[2:0]), 32'h4);
    check(32'(bp), 32'hff);
    repeat (20) @(posedge clk_i);
    apb(8'h08, 1'b0, 32'h0);
    check(32'(rd[0]), 32'h1);
    check(32'(pad_oe), 32'h1);
    p = pad_o;
    repeat (2) @(posedge clk_i);
    check(32'(pad_o ^ p), 32'h1);
    apb(8'h0c, 1'b1, 32'hff);
    check(32'(err), 32'h1);
    apb(8'h0c, 1'b0, 32'h0);
    check(rd, 32'h0);
    foreach (modes[i])
    begin
      apb(8'h00, 1'b1, 32'(modes[i]));
      third = !modes[i][2] && modes[i][1:0] != 2'h0;
      wait_rise();
      t = $time;
      wait_rise();
      check(32'(($time - t) / 25), 32'd96);
      @(posedge clk_i);
      check(32'(bp[1]), modes[i][1:0] == 2'h0 ? 32'h3 : 32'h1);
      check(32'(bp[2]), modes[i][1:0] <= 2'h1 ? 32'h3 : 32'h1);
      check(32'(seg[0]), 32'h0);
      check(32'(seg[1]), third ? 32'h2 : 32'h3);
      check(32'(sync_oe), 32'h1);
    end
    // Output bank switch in 1:2, third bias: row 0 shows the upper bits
    apb(8'h00, 1'b1, 32'h49);
    wait_rise();
    @(posedge clk_i);
    check(32'(seg[1:0]), 32'h2);
    wait_rise();
    repeat (30) @(posedge clk_i);
    sync_pull <= 1'b1;
    repeat (4) @(posedge clk_i);
    sync_pull <= 1'b0;
    apb(8'h08, 1'b0, 32'h0);
    check(32'(rd[6:4]), 32'h0);
    check(32'(dc_stuck), 32'h0);
    strap <= 1'b1;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    strap <= 1'b0;
    check(32'(pad_oe), 32'h0);
    check(32'(bp), 32'hff);
    apb(8'h08, 1'b0, 32'h0);
    check(32'(rd[2:1]), 32'h3);
    check(32'(pad_oe), 32'h0);
    apb(8'h00, 1'b0, 32'h0);
    check(rd, 32'h03);
    apb(8'h00, 1'b1, 32'h0b);
    wait_rise();
    t = $time;
    wait_rise();
    check(32'(($time - t) / 25), 32'd240);
    check(32'(dc_stuck), 32'h0);
    summarize();
  end
endmodule
